// ==== irqp_checker.sv ====
// Port checks for the priority and vector base block
`timescale 1ns/10ps
`default_nettype none
module irqp_checker #(
  parameter logic [7:0] VECTOR_FIRST = 8'h40
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        irq_out,
  input wire logic        core_irq_valid,
  input wire logic [1:0]  core_irq_level,
  input wire logic [20:0] vector_address_bus
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Read path, reserved bits and unmapped offsets
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_vbase_gap: assert property (reg_rd && reg_addr == 4'hA |=> reg_rdata[15:13] == 3'h0)
    else $error("vector base top bits set");
  a_six_gap: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata[5:4] == 2'h0)
    else $error("register six gap set");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 4'hF |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  // Vector address and winner outputs
  a_vbase_drive: assert property (reg_wr && reg_addr == 4'hA |-> ##2
    vector_address_bus[20:8] == $past(reg_wdata[12:0], 2))
    else $error("vector base not on bus");
  a_valid_code: assert property (core_irq_valid == (core_irq_level != 2'h0))
    else $error("level code and valid disagree");
  a_valid_irq: assert property (core_irq_valid |-> irq_out)
    else $error("winner without interrupt");
  a_low_range: assert property (core_irq_valid |->
    (vector_address_bus[7:0] - VECTOR_FIRST) < 8'h0F)
    else $error("vector number out of range");
  a_low_none: assert property (!core_irq_valid && !$past(reset) && !$past(reset, 2) |->
    vector_address_bus[7:0] == VECTOR_FIRST)
    else $error("idle vector number wrong");
endmodule : irqp_checker
bind irqp_vector_base irqp_checker #(.VECTOR_FIRST(VECTOR_FIRST)) u_irqp_checker (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out), .core_irq_valid(core_irq_valid),
  .core_irq_level(core_irq_level), .vector_address_bus(vector_address_bus));
`default_nettype wire

// ==== irqp_consts.svh ====
// Offsets, field positions, masks and reset values of the priority and vector base block
// Overview of operation
// RULE1 - Two-bit field: 00 off, else levels 0-2
// RULE2 - Governed requests reach levels zero to two
// RULE3 - Every priority field resets to disabled code
// RULE4 - Reserved bits read zero, writes ignored
// RULE5 - Serial1 idle field bits 5:4, 7:6 reserved
// RULE6 - Serial1 transmit empty field bits 3:2
// RULE7 - Sync serial0 transmit empty field bits 1:0
// RULE8 - Serial0 idle field bits 9:8, 11:10 reserved
// RULE9 - Serial0 transmit empty field bits 7:6
// RULE10 - Timer A channel 3 field bits 5:4
// RULE11 - Timer A channel 2 field bits 3:2
// RULE12 - Converter B done field bits 1:0
// RULE13 - Register six: timers C0, D3-D0, decoder
// RULE14 - Vector base at A, 13 bits, resets zero
// RULE15 - Vector base drives upper 13 address bits
// RULE16 - Winner's eight-bit vector number fills bottom
// RULE17 - Highest level wins, ties lowest index
`ifndef IRQP_CONSTS_SVH
`define IRQP_CONSTS_SVH

// Register offsets
`define IRQP_OFF_STATUS    4'h1
`define IRQP_OFF_MASK      4'h2
`define IRQP_OFF_PRI_FIVE  4'h5
`define IRQP_OFF_PRI_SIX   4'h6
`define IRQP_OFF_PRI_EIGHT 4'h8
`define IRQP_OFF_PRI_NINE  4'h9
`define IRQP_OFF_VBASE     4'hA

// Writable bit masks; all other bits are reserved
`define IRQP_WMASK_PRI_FIVE  16'h003F
`define IRQP_WMASK_PRI_SIX   16'hFFCF
`define IRQP_WMASK_PRI_EIGHT 16'h03FC
`define IRQP_WMASK_PRI_NINE  16'h0003
`define IRQP_WMASK_VBASE     16'h1FFF
`define IRQP_WMASK_EVENTS    16'h7FFF

// Reset values
`define IRQP_RST_WORD  16'h0000
`define IRQP_RST_VAB   21'h00_0000

// Number of governed requests
`define IRQP_NUM_REQ   15

`endif

// ==== irqp_core_model.sv ====
// Core model that takes the vector address while a request is offered
`timescale 1ns/10ps
`default_nettype none
module irqp_core_model (
  input wire logic        clk,
  input wire logic        core_irq_valid,
  input wire logic [20:0] vector_address_bus,
  output var logic [20:0] taken_vec
);
  // Latch the full address, base on top and vector number below
  always_ff @(posedge clk) if (core_irq_valid) taken_vec <= vector_address_bus;
endmodule : irqp_core_model
`default_nettype wire

// ==== irqp_pkg.sv ====
// Types shared by the priority and vector base block
package irqp_pkg;
  // Priority field code; a larger code is a higher level
  typedef enum logic [1:0] {
    IRQP_LVL_OFF = 2'b00,
    IRQP_LVL_0   = 2'b01,
    IRQP_LVL_1   = 2'b10,
    IRQP_LVL_2   = 2'b11
  } irqp_level_t;
endpackage : irqp_pkg

// ==== irqp_vector_base.sv ====
// Priority level fields, vector base register and vector selection for the core
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "irqp_consts.svh"

module irqp_vector_base #(
  parameter logic [7:0] VECTOR_FIRST = 8'h40
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [15:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic [15:0]                     reg_rdata,
  input  wire logic [`IRQP_NUM_REQ-1:0]   req_pending,
  output logic                            irq_out,
  output logic                            core_irq_valid,
  output logic [1:0]                      core_irq_level,
  output logic [20:0]                     vector_address_bus
);

  localparam int NREQ = `IRQP_NUM_REQ;

  // Register state
  logic [15:0] pri_five_r;
  logic [15:0] pri_six_r;
  logic [15:0] pri_eight_r;
  logic [15:0] pri_nine_r;
  logic [15:0] vector_table_base_r;
  logic [15:0] status_r;
  logic [15:0] mask_r;
  logic [15:0] rdata_r;
  logic        irq_r;
  logic        valid_r;
  logic [1:0]  level_r;
  logic [20:0] vab_r;

  // Next values
  logic [15:0] pri_five_nxt;
  logic [15:0] pri_six_nxt;
  logic [15:0] pri_eight_nxt;
  logic [15:0] pri_nine_nxt;
  logic [15:0] vbase_nxt;
  logic [15:0] status_nxt;
  logic [15:0] mask_nxt;
  logic [15:0] rdata_nxt;
  logic [20:0] vab_nxt;

  // Address decode
  wire sel_status = (reg_addr == `IRQP_OFF_STATUS);
  wire sel_mask   = (reg_addr == `IRQP_OFF_MASK);
  wire sel_five   = (reg_addr == `IRQP_OFF_PRI_FIVE);
  wire sel_six    = (reg_addr == `IRQP_OFF_PRI_SIX);
  wire sel_eight  = (reg_addr == `IRQP_OFF_PRI_EIGHT);
  wire sel_nine   = (reg_addr == `IRQP_OFF_PRI_NINE);
  wire sel_vbase  = (reg_addr == `IRQP_OFF_VBASE);

  // Writes keep only the implemented bits
  assign pri_five_nxt  = (reg_wr && sel_five)
                       ? (reg_wdata & `IRQP_WMASK_PRI_FIVE) : pri_five_r;    // RULE4
  assign pri_six_nxt   = (reg_wr && sel_six)
                       ? (reg_wdata & `IRQP_WMASK_PRI_SIX) : pri_six_r;      // RULE13
  assign pri_eight_nxt = (reg_wr && sel_eight)
                       ? (reg_wdata & `IRQP_WMASK_PRI_EIGHT) : pri_eight_r;  // RULE4
  assign pri_nine_nxt  = (reg_wr && sel_nine)
                       ? (reg_wdata & `IRQP_WMASK_PRI_NINE) : pri_nine_r;    // RULE4
  assign vbase_nxt     = (reg_wr && sel_vbase)
                       ? (reg_wdata & `IRQP_WMASK_VBASE) : vector_table_base_r; // RULE14
  assign mask_nxt      = (reg_wr && sel_mask)
                       ? (reg_wdata & `IRQP_WMASK_EVENTS) : mask_r;

  // Sticky status: a pending line sets its bit, writing one clears, set wins
  wire [15:0] status_clr = (reg_wr && sel_status) ? reg_wdata : `IRQP_RST_WORD;
  wire [15:0] status_set = {1'b0, req_pending} & `IRQP_WMASK_EVENTS;
  assign status_nxt = (status_r & ~status_clr) | status_set;

  // Read multiplexer; unmapped offsets and reserved bits read zero
  wire [15:0] rd_mux = sel_status ? status_r
                     : sel_mask   ? mask_r
                     : sel_five   ? pri_five_r
                     : sel_six    ? pri_six_r
                     : sel_eight  ? pri_eight_r
                     : sel_nine   ? pri_nine_r
                     : sel_vbase  ? vector_table_base_r
                     : `IRQP_RST_WORD;                                       // RULE4
  assign rdata_nxt = reg_rd ? rd_mux : `IRQP_RST_WORD;

  // Per-request priority field extraction
  logic [1:0] req_level [NREQ];
  assign req_level[0]  = pri_five_r[1:0];     // RULE7
  assign req_level[1]  = pri_five_r[3:2];     // RULE6
  assign req_level[2]  = pri_five_r[5:4];     // RULE5
  assign req_level[3]  = pri_eight_r[3:2];    // RULE11
  assign req_level[4]  = pri_eight_r[5:4];    // RULE10
  assign req_level[5]  = pri_eight_r[7:6];    // RULE9
  assign req_level[6]  = pri_eight_r[9:8];    // RULE8
  assign req_level[7]  = pri_nine_r[1:0];     // RULE12
  assign req_level[8]  = pri_six_r[1:0];      // RULE13
  assign req_level[9]  = pri_six_r[3:2];      // RULE13
  assign req_level[10] = pri_six_r[7:6];      // RULE13
  assign req_level[11] = pri_six_r[9:8];      // RULE13
  assign req_level[12] = pri_six_r[11:10];    // RULE13
  assign req_level[13] = pri_six_r[13:12];    // RULE13
  assign req_level[14] = pri_six_r[15:14];    // RULE13

  // Arbitration chain from the top index down so the lowest index wins ties
  logic [1:0] chain_rank [NREQ+1];
  logic [7:0] chain_idx  [NREQ+1];
  assign chain_rank[NREQ] = irqp_pkg::IRQP_LVL_OFF;
  assign chain_idx[NREQ]  = 8'h00;

  genvar gi;
  generate
    // Each stage compares with the stages above it, so the loop may count upwards
    for (gi = 0; gi < NREQ; gi++) begin : g_arb
      // Code 00 never competes; codes 01 to 11 rank as levels 0 to 2
      wire       live = status_r[gi] && mask_r[gi]
                        && (req_level[gi] != irqp_pkg::IRQP_LVL_OFF);           // RULE1
      wire [1:0] rank = live ? req_level[gi] : irqp_pkg::IRQP_LVL_OFF;          // RULE2
      wire       take = live && (rank >= chain_rank[gi+1]);                     // RULE17
      assign chain_rank[gi] = take ? rank : chain_rank[gi+1];
      assign chain_idx[gi]  = take ? 8'(gi) : chain_idx[gi+1];
    end
  endgenerate

  wire        any_live   = (chain_rank[0] != irqp_pkg::IRQP_LVL_OFF);
  wire [7:0]  win_vector = VECTOR_FIRST + chain_idx[0];                        // RULE16
  // Vector base on top, winner's vector number below
  assign vab_nxt = {vector_table_base_r[12:0], win_vector};                    // RULE15

  // Priority and vector base registers, all cleared to zero at reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pri_five_r          <= `IRQP_RST_WORD;   // RULE3
      pri_six_r           <= `IRQP_RST_WORD;   // RULE3
      pri_eight_r         <= `IRQP_RST_WORD;   // RULE3
      pri_nine_r          <= `IRQP_RST_WORD;   // RULE3
      vector_table_base_r <= `IRQP_RST_WORD;   // RULE14
    end else begin
      pri_five_r          <= pri_five_nxt;
      pri_six_r           <= pri_six_nxt;
      pri_eight_r         <= pri_eight_nxt;
      pri_nine_r          <= pri_nine_nxt;
      vector_table_base_r <= vbase_nxt;
    end
  end

  // Status, mask and read data
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_r <= `IRQP_RST_WORD;
      mask_r   <= `IRQP_RST_WORD;
      rdata_r  <= `IRQP_RST_WORD;
    end else begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Outputs towards the core
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_r   <= 1'b0;
      valid_r <= 1'b0;
      level_r <= 2'b00;
      vab_r   <= `IRQP_RST_VAB;
    end else begin
      irq_r   <= |(status_r & mask_r);
      valid_r <= any_live;
      level_r <= chain_rank[0];
      vab_r   <= vab_nxt;
    end
  end

  assign reg_rdata          = rdata_r;
  assign irq_out            = irq_r;
  assign core_irq_valid     = valid_r;
  assign core_irq_level     = level_r;
  assign vector_address_bus = vab_r;

endmodule : irqp_vector_base
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the priority and vector base block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk, reset, reg_wr, reg_rd, irq_out, core_irq_valid;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic [14:0] req_pending;
  logic [1:0]  core_irq_level;
  logic [20:0] vector_address_bus, taken_vec;
  int          error_cnt = 0, comparisons = 0;
  // Rows: offset written with all ones, and the value it reads back
  logic [3:0]  row_a [7] = '{4'h6, 4'hA, 4'h5, 4'h8, 4'h9, 4'h2, 4'hF};
  logic [15:0] row_e [7] = '{16'hFFCF, 16'h1FFF, 16'h003F, 16'h03FC, 16'h0003, 16'h7FFF, 16'h0000};
  irqp_vector_base u_irqp_vector_base (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req_pending(req_pending), .irq_out(irq_out), .core_irq_valid(core_irq_valid),
    .core_irq_level(core_irq_level), .vector_address_bus(vector_address_bus));
  irqp_core_model u_irqp_core_model (.clk(clk), .core_irq_valid(core_irq_valid),
    .vector_address_bus(vector_address_bus), .taken_vec(taken_vec));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic test_done;
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Watchdog against a hung sequence
  initial begin
    #40000;
    error_cnt++;
    test_done;
  end
  // Main sequence
  initial begin
    reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 4'h0; reg_wdata = 16'h0000; req_pending = 15'h0000;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    foreach (row_a[i]) begin
      rd(row_a[i], rv);
      chk({5'h00, rv}, 21'h00_0000);
      wr(row_a[i], 16'hFFFF);
      rd(row_a[i], rv);
      chk({5'h00, rv}, {5'h00, row_e[i]});
    end
    // Three requests: one disabled, one at level 1, one at level 2
    wr(4'h5, 16'h0000); wr(4'h6, 16'h0000); wr(4'h8, 16'h0080);
    wr(4'h9, 16'h0003); wr(4'hA, 16'h1ABC);
    @(posedge clk) req_pending <= 15'h00A1;
    @(posedge clk) req_pending <= 15'h0000;
    repeat (3) @(posedge clk);
    #1 chk(21'(core_irq_level), 21'(irqp_pkg::IRQP_LVL_2));
    chk(vector_address_bus, 21'h1A_BC47);
    chk(taken_vec, 21'h1A_BC47);
    // Clearing the winner hands the vector to the level 1 request
    wr(4'h1, 16'h0080);
    repeat (2) @(posedge clk);
    #1 chk(21'(core_irq_level), 21'(irqp_pkg::IRQP_LVL_1));
    chk(vector_address_bus, 21'h1A_BC45);
    // Masking it leaves only the disabled request pending
    wr(4'h2, 16'h7FDF);
    repeat (2) @(posedge clk);
    #1 chk({19'h0_0000, irq_out, core_irq_valid}, 21'h00_0002);
    chk(vector_address_bus, 21'h1A_BC40);
    // Two requests at level 1 together: the lower index wins the tie
    wr(4'h2, 16'h7FFF); wr(4'h8, 16'h0280);
    @(posedge clk) req_pending <= 15'h0060;
    @(posedge clk) req_pending <= 15'h0000;
    repeat (3) @(posedge clk);
    #1 chk(21'(core_irq_level), 21'(irqp_pkg::IRQP_LVL_1));
    chk(vector_address_bus, 21'h1A_BC45);
    // Reset in mid-run clears the registers and the vector base on the bus
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    rd(4'hA, rv);
    chk({5'h00, rv}, 21'h00_0000);
    chk(vector_address_bus, 21'h00_0040);
    chk({19'h0_0000, irq_out, core_irq_valid}, 21'h00_0000);
    rd(4'h9, rv);
    chk({5'h00, rv}, 21'h00_0000);
    test_done;
  end
endmodule : tb_top
`default_nettype wire
